// ===== logic/scm_cfg_ctrl.sv
// Purpose: power-up, configuration load, initialization and user mode sequencing
// Assumes: configuration words arrive on the system clock with valid/ready
// Notes:   pins (reconfigure, chain enable, scheme) pass two flip-flops first
//
// Function
// - volatile storage: full data load needed after every power-up before operating.
// - user I/O stays tri-stated at power-up, before and during configuration.
// - after load, initialization resets registers, enables I/O, then runs.
// - configuration plus initialization is command mode; user mode follows initialization.
// - reconfigure pin forces command mode; new load, reinit, back to user.
// - whole reconfiguration finishes in under 100 ms; an overrun is only flagged on O_RECONF_LATE, not prevented.
// - exactly one of three configuration schemes is used per load.
// - devices chain; chain output of one enables the next device's load.
`timescale 1ns/100ps
`default_nettype none
module scm_cfg_ctrl import scm_pkg::*; #(
    parameter int DATA_W           = DATA_W_DEF,
    parameter int CFG_WORDS        = CFG_WORDS_DEF,
    parameter int RECONF_LIMIT     = RECONF_LIMIT_CYC
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RESET_N,
    input  wire logic              I_RECONFIG_N,
    input  wire logic              I_CHAIN_ENABLE_IN_N,
    input  wire logic [1:0]        I_SCHEME,
    input  wire logic              I_DATA_VALID,
    input  wire logic [DATA_W-1:0] I_DATA,
    output logic                   O_DATA_READY,
    output logic                   O_COMMAND_MODE,
    output logic                   O_USER_MODE,
    output logic                   O_REG_RESET,
    output logic                   O_IO_OE,
    output logic                   O_CFG_DONE,
    output logic                   O_CHAIN_ENABLE_OUT_N,
    output logic                   O_RECONF_LATE
);
    scm_state_t       st_r, st_nxt;
    logic             rcf_s1_r, rcf_s2_r, ce_s1_r, ce_s2_r;
    logic [1:0]       sch_s1_r, sch_s2_r, scheme_r, scheme_nxt;
    logic [15:0]      wcnt_r, wcnt_nxt;
    logic [3:0]       icnt_r, icnt_nxt;
    logic [23:0]      tmr_r, tmr_nxt;
    logic             busy_r, busy_nxt, late_nxt;
    logic [3:0]       div_r, div_nxt;
    logic             cmd_nxt, usr_nxt, rrst_nxt, ioe_nxt, done_nxt, ceo_n_nxt;
    logic             reconf_act, ce_act, scheme_ok, drain_en, take, last_word;
    logic             buf_valid, buf_ready;
    logic [DATA_W-1:0] buf_data;

    function automatic logic scheme_valid(input logic [1:0] s);
        scheme_valid = (s == SCHEME_MEMDEV) || (s == PASSIVE_SERIAL_SCHEME) || (s == PASSIVE_SERIAL_ASYNC_SCHEME);
    endfunction

    // pin synchronisers; only the second stage is read
    always_ff @(posedge I_CLK) begin
        rcf_s1_r <= I_RECONFIG_N;
        rcf_s2_r <= rcf_s1_r;
        ce_s1_r  <= I_CHAIN_ENABLE_IN_N;
        ce_s2_r  <= ce_s1_r;
        sch_s1_r <= I_SCHEME;
        sch_s2_r <= sch_s1_r;
    end

    assign reconf_act = I_RESET_N && !rcf_s2_r;
    assign ce_act     = !ce_s2_r;
    assign scheme_ok  = scheme_valid(sch_s2_r);
    assign drain_en   = (div_r == 4'(DRAIN_DIV - 1));
    // words drain at a divided rate so the source really sees back-pressure
    assign buf_ready  = (st_r == ST_LOAD) && ce_act && drain_en && !reconf_act;
    assign take       = buf_ready && buf_valid;
    assign last_word  = (wcnt_r == 16'(CFG_WORDS - 1));

    scm_skid_buf #(.W(DATA_W)) u_buf (
        .i_clk       (I_CLK),
        .i_reset_n   (I_RESET_N),
        .i_flush     (reconf_act),
        .i_in_valid  (I_DATA_VALID),
        .i_in_data   (I_DATA),
        .o_in_ready  (O_DATA_READY),
        .o_out_valid (buf_valid),
        .o_out_data  (buf_data),
        .i_out_ready (buf_ready)
    );

    always_comb begin
        st_nxt     = st_r;
        wcnt_nxt   = wcnt_r;
        icnt_nxt   = icnt_r;
        scheme_nxt = scheme_r;
        div_nxt    = drain_en ? 4'h0 : 4'(div_r + 4'h1);
        if (reconf_act) begin
            st_nxt   = ST_WAIT;
            wcnt_nxt = 16'h0;
        end else begin
            case (st_r)
                ST_WAIT: begin
                    if (ce_act && scheme_ok) begin
                        st_nxt     = ST_LOAD;
                        scheme_nxt = sch_s2_r;
                        wcnt_nxt   = 16'h0;
                    end
                end
                ST_LOAD: begin
                    if (take && last_word) begin
                        st_nxt   = ST_INIT_RST;
                        icnt_nxt = 4'h0;
                    end else if (take) begin
                        wcnt_nxt = 16'(wcnt_r + 16'h1);
                    end
                end
                ST_INIT_RST: begin
                    icnt_nxt = 4'(icnt_r + 4'h1);
                    if (icnt_r == 4'(INIT_RST_CYC - 1)) begin
                        st_nxt = ST_INIT_IOEN;
                    end
                end
                ST_INIT_IOEN: st_nxt = ST_USER;
                default: st_nxt = ST_USER;
            endcase
        end
        cmd_nxt   = (st_nxt != ST_USER);
        usr_nxt   = (st_nxt == ST_USER);
        rrst_nxt  = (st_nxt == ST_INIT_RST);
        ioe_nxt   = (st_nxt == ST_INIT_IOEN) || (st_nxt == ST_USER);
        done_nxt  = (st_nxt == ST_INIT_RST) || ioe_nxt;
        ceo_n_nxt = !(done_nxt && ce_act);
    end

    // reconfiguration watchdog: flags a sequence that overruns its limit
    always_comb begin
        busy_nxt = busy_r;
        tmr_nxt  = tmr_r;
        late_nxt = O_RECONF_LATE;
        if (reconf_act && (st_r != ST_WAIT || !busy_r)) begin
            busy_nxt = 1'b1;
            tmr_nxt  = 24'h0;
            // an overrun landing on the restart edge still wins
            late_nxt = busy_r && (tmr_r == 24'(RECONF_LIMIT - 1));
        end else if (busy_r && st_nxt == ST_USER) begin
            busy_nxt = 1'b0;
        end else if (busy_r) begin
            tmr_nxt = 24'(tmr_r + 24'h1);
            if (tmr_r == 24'(RECONF_LIMIT - 1)) begin
                late_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            st_r                 <= ST_WAIT;
            wcnt_r               <= 16'h0;
            icnt_r               <= 4'h0;
            scheme_r             <= SCHEME_RST;
            div_r                <= 4'h0;
            busy_r               <= 1'b0;
            tmr_r                <= 24'h0;
            O_RECONF_LATE        <= 1'b0;
            O_COMMAND_MODE       <= 1'b1;
            O_USER_MODE          <= 1'b0;
            O_REG_RESET          <= 1'b0;
            O_IO_OE              <= 1'b0;
            O_CFG_DONE           <= 1'b0;
            O_CHAIN_ENABLE_OUT_N <= 1'b1;
        end else begin
            st_r                 <= st_nxt;
            wcnt_r               <= wcnt_nxt;
            icnt_r               <= icnt_nxt;
            scheme_r             <= scheme_nxt;
            div_r                <= div_nxt;
            busy_r               <= busy_nxt;
            tmr_r                <= tmr_nxt;
            O_RECONF_LATE        <= late_nxt;
            O_COMMAND_MODE       <= cmd_nxt;
            O_USER_MODE          <= usr_nxt;
            O_REG_RESET          <= rrst_nxt;
            O_IO_OE              <= ioe_nxt;
            O_CFG_DONE           <= done_nxt;
            O_CHAIN_ENABLE_OUT_N <= ceo_n_nxt;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    sequence s_load_end;
        take && last_word && !reconf_act;
    endsequence
    sequence s_init_walk;
        O_REG_RESET [*4] ##1 (O_IO_OE && !O_USER_MODE) ##1 O_USER_MODE;
    endsequence

    property p_full_load;
        (st_r == ST_INIT_RST && $past(st_r) == ST_LOAD) |-> $past(wcnt_r) == 16'(CFG_WORDS - 1);
    endproperty
    a_full_load: assert property (p_full_load) else $error("init entered before full load");
    property p_io_hiz;
        O_IO_OE |-> (st_r == ST_INIT_IOEN || st_r == ST_USER);
    endproperty
    a_io_hiz: assert property (p_io_hiz) else $error("io enabled during configuration");
    // a reconfigure pin aborts the walk, so it aborts the check too
    property p_init_seq;
        disable iff (!I_RESET_N || reconf_act)
        s_load_end |=> s_init_walk;
    endproperty
    a_init_seq: assert property (p_init_seq) else $error("initialization sequence wrong");
    property p_mode_excl;
        O_USER_MODE != O_COMMAND_MODE;
    endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("mode outputs not exclusive");
    property p_user_after_init;
        $rose(O_USER_MODE) |-> $past(O_IO_OE) && !$past(O_USER_MODE);
    endproperty
    a_user_after_init: assert property (p_user_after_init) else $error("user mode without init");
    property p_reconf_cmd;
        reconf_act |=> O_COMMAND_MODE && !O_IO_OE && !O_CFG_DONE;
    endproperty
    a_reconf_cmd: assert property (p_reconf_cmd) else $error("reconfigure did not force command mode");
    property p_late;
        (busy_r && !reconf_act && st_nxt != ST_USER && tmr_r == 24'(RECONF_LIMIT - 1)) |=> O_RECONF_LATE;
    endproperty
    a_late: assert property (p_late) else $error("overrun not flagged");
    property p_scheme_hold;
        (st_r == ST_LOAD && $past(st_r) == ST_LOAD) |-> $stable(scheme_r) && scheme_valid(scheme_r);
    endproperty
    a_scheme_hold: assert property (p_scheme_hold) else $error("scheme changed during load");
    property p_take_needs_ce;
        take |-> ce_act && st_r == ST_LOAD;
    endproperty
    a_take_needs_ce: assert property (p_take_needs_ce) else $error("load without chain enable");
    property p_chain_out;
        !O_CHAIN_ENABLE_OUT_N |-> O_CFG_DONE && $past(ce_act);
    endproperty
    a_chain_out: assert property (p_chain_out) else $error("chain output early");
endmodule
`default_nettype wire

// ===== logic/scm_pkg.sv
// Purpose: constants for the configuration and mode controller
// Assumes: 125 MHz system clock
// Notes:   scheme codes are sampled from strap pins
`default_nettype none
package scm_pkg;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          RECONF_LIMIT_MS = 100;
    localparam int          RECONF_LIMIT_CYC = RECONF_LIMIT_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int          CFG_WORDS_DEF   = 16;
    localparam int          INIT_RST_CYC    = 4;
    localparam int          DRAIN_DIV       = 2;
    localparam int          DATA_W_DEF      = 8;
    localparam logic [1:0]  SCHEME_MEMDEV   = 2'h0;
    localparam logic [1:0]  PASSIVE_SERIAL_SCHEME       = 2'h1;
    localparam logic [1:0]  PASSIVE_SERIAL_ASYNC_SCHEME = 2'h2;
    localparam logic [1:0]  SCHEME_RST      = 2'h0;
    typedef enum logic [2:0] {ST_WAIT, ST_LOAD, ST_INIT_RST, ST_INIT_IOEN, ST_USER} scm_state_t;
endpackage
`default_nettype wire

// ===== logic/scm_skid_buf.sv
// Purpose: two-entry buffer between configuration source and loader
// Assumes: both sides on one clock
// Notes:   ready is registered from the next count, so a full buffer refuses until a word leaves
`timescale 1ns/100ps
`default_nettype none
module scm_skid_buf #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_flush,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic         wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0]   cnt_r, cnt_nxt;
    logic         rdy_r, rdy_nxt;
    logic         push, pop;

    always_comb begin
        push    = i_in_valid && rdy_r;
        pop     = (cnt_r != 2'h0) && i_out_ready;
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = i_in_data;
            wp_nxt        = ~wp_r;
        end
        if (pop) begin
            rp_nxt = ~rp_r;
        end
        cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
        if (i_flush) begin
            wp_nxt  = 1'b0;
            rp_nxt  = 1'b0;
            cnt_nxt = 2'h0;
        end
        rdy_nxt = (cnt_nxt != 2'h2);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
            rdy_r <= 1'b0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
        mem_r <= mem_nxt;
    end

    assign o_in_ready  = rdy_r;
    assign o_out_valid = (cnt_r != 2'h0);
    assign o_out_data  = mem_r[rp_r];
endmodule
`default_nettype wire

// ===== tb/scm_src_model.sv
// Purpose: configuration source on the far side of the data port
// Assumes: 8-bit words, one clock
// Notes:   idle data toggles so a stale word is never mistaken for a new one
`timescale 1ns/100ps
`default_nettype none
module scm_src_model (
    input  wire logic       i_clk,
    input  wire logic       i_stall,
    input  wire logic [7:0] i_word,
    input  wire logic       i_ready,
    output var logic        o_valid,
    output var logic [7:0]  o_data,
    output var int          o_sent
);
    int         left = 0;
    logic       tk;
    logic       st;
    logic [7:0] w;
    task automatic send(input int n);
        left = left + n;
    endtask
    initial begin
        o_valid = 1'b0;
        o_data  = 8'h00;
        o_sent  = 0;
    end
    // words held until taken, offered without help once queued
    always @(posedge i_clk) begin
        tk = o_valid & i_ready;
        st = i_stall;
        w  = i_word;
        if (tk) begin
            o_sent = o_sent + 1;
            left   = left - 1;
        end
        #1;
        if (!o_valid || tk) begin
            if (left > 0 && !st) begin
                o_valid = 1'b1;
                o_data  = w;
            end else begin
                o_valid = 1'b0;
                o_data  = ~o_data;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/scm_cfg_ctrl_test.sv
// Purpose: self-checking bench for the configuration and mode controller
// Assumes: 16-word loads, watchdog shortened to 200 cycles
// Notes:   a run past the cycle ceiling counts as one mismatch
`timescale 1ns/100ps
`default_nettype none
module scm_cfg_ctrl_test import scm_pkg::*;;
    localparam int NW  = 16;
    localparam int LIM = 200;
    logic        I_CLK = 1'b0, I_RESET_N = 1'b0, I_RECONFIG_N = 1'b1, I_CHAIN_ENABLE_IN_N = 1'b1;
    logic [1:0]  I_SCHEME = SCHEME_MEMDEV;
    logic        I_DATA_VALID, O_DATA_READY, O_COMMAND_MODE, O_USER_MODE, O_REG_RESET;
    logic        O_IO_OE, O_CFG_DONE, O_CHAIN_ENABLE_OUT_N, O_RECONF_LATE;
    logic [7:0]  I_DATA;
    logic        stall = 1'b0, stall_en = 1'b0;
    logic [7:0]  word = 8'h00;
    logic [31:0] lfsr = 32'h22d0;
    logic [3:0]  exp_q[$];
    int          n_errors = 0, samples_checked = 0, cyc = 0, sent, base = 0;
    scm_cfg_ctrl #(.CFG_WORDS(NW), .RECONF_LIMIT(LIM)) i_dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
        .I_RECONFIG_N(I_RECONFIG_N), .I_CHAIN_ENABLE_IN_N(I_CHAIN_ENABLE_IN_N), .I_SCHEME(I_SCHEME),
        .I_DATA_VALID(I_DATA_VALID), .I_DATA(I_DATA), .O_DATA_READY(O_DATA_READY),
        .O_COMMAND_MODE(O_COMMAND_MODE), .O_USER_MODE(O_USER_MODE), .O_REG_RESET(O_REG_RESET),
        .O_IO_OE(O_IO_OE), .O_CFG_DONE(O_CFG_DONE), .O_CHAIN_ENABLE_OUT_N(O_CHAIN_ENABLE_OUT_N),
        .O_RECONF_LATE(O_RECONF_LATE));
    scm_src_model i_src (.i_clk(I_CLK), .i_stall(stall), .i_word(word), .i_ready(O_DATA_READY),
        .o_valid(I_DATA_VALID), .o_data(I_DATA), .o_sent(sent));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    initial begin
        forever #4 I_CLK = ~I_CLK;
    end
    always @(posedge I_CLK) begin
        #1;
        lfsr  = lfsr_next(lfsr);
        word  = lfsr[15:8];
        stall = stall_en & lfsr[0] & lfsr[3];
    end
    // ceiling well above the several hundred cycles the sequence needs
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 10000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask
    task automatic boot(input logic late, input int n_new);
        int n;
        n = 0;
        i_src.send(n_new);
        while (O_CFG_DONE !== 1'b1 && n < 600) begin
            chk({O_IO_OE, O_USER_MODE, O_COMMAND_MODE, O_CHAIN_ENABLE_OUT_N}, 4'h3);
            step(1);
            n++;
        end
        chk(8'(sent - base), 8'(NW));
        chk(O_CHAIN_ENABLE_OUT_N, 1'b0);
        exp_q = {};
        repeat (INIT_RST_CYC) exp_q.push_back(4'h9);
        exp_q.push_back(4'h5);
        exp_q.push_back(4'h6);
        while (exp_q.size() > 0) begin
            chk({O_REG_RESET, O_IO_OE, O_USER_MODE, O_COMMAND_MODE}, exp_q.pop_front());
            step(1);
        end
        chk(O_RECONF_LATE, late);
    endtask
    task automatic reconf(input int hold, input logic [1:0] sch);
        I_RECONFIG_N = 1'b0;
        I_SCHEME     = sch;
        step(hold);
        chk({O_COMMAND_MODE, O_IO_OE, O_CFG_DONE, O_USER_MODE}, 4'h8);
        I_RECONFIG_N = 1'b1;
        // words offered while the synced pin still flushes would be lost
        step(3);
        base         = sent;
    endtask
    initial begin
        // chain input inactive from the start: buffer fills, nothing loads
        step(16);
        I_RESET_N           = 1'b1;
        i_src.send(NW);
        step(100);
        chk(8'(sent - base), 8'h02);
        chk({O_CFG_DONE, O_CHAIN_ENABLE_OUT_N, O_IO_OE, O_DATA_READY}, 4'h4);
        I_CHAIN_ENABLE_IN_N = 1'b0;
        boot(1'b0, 0);
        // words beyond one load stay parked and back-pressure the source
        base = sent;
        i_src.send(2);
        step(20);
        chk(8'(sent - base), 8'h02);
        chk(O_DATA_READY, 1'b0);
        stall_en = 1'b1;
        for (int s = 0; s < 3; s++) begin
            reconf(6, s[1:0]);
            boot(1'b0, NW);
        end
        reconf(6, 2'h3);
        i_src.send(NW);
        step(100);
        chk({O_CFG_DONE, 7'(sent - base)}, 8'h02);
        I_SCHEME = PASSIVE_SERIAL_SCHEME;
        boot(1'b0, 0);
        reconf(LIM + 50, PASSIVE_SERIAL_ASYNC_SCHEME);
        boot(1'b1, NW);
        reconf(6, SCHEME_MEMDEV);
        boot(1'b0, NW);
        I_RESET_N = 1'b0;
        step(4);
        chk({O_COMMAND_MODE, O_USER_MODE, O_IO_OE, O_CFG_DONE, O_CHAIN_ENABLE_OUT_N, O_DATA_READY}, 8'h22);
        I_RESET_N = 1'b1;
        base      = sent;
        boot(1'b0, NW);
        stop_test();
    end
endmodule
`default_nettype wire
